// File: design/rfs_defines.vh
// Purpose: Constants for the receive channel filter and signal strength block.
// Assumes: APB with 32-bit data, one register per aligned word.
// Notes: Offsets are byte addresses.
`ifndef RFS_DEFINES_VH
`define RFS_DEFINES_VH
`define RFS_OFF_BWCFG 12'h000
`define RFS_OFF_INST 12'h004
`define RFS_OFF_PKT 12'h008
`define RFS_OFF_STAT 12'h00c
`define RFS_OFF_CLR 12'h010
`define RFS_OFF_IEN 12'h014
`define RFS_OFF_DIV 12'h018
`define RFS_BW_RESET 5'h15
`define RFS_MANT_LSB 3
`define RFS_EXP_MSB 2
`define RFS_DIV_16 5'h10
`define RFS_DIV_20 5'h14
`define RFS_DIV_24 5'h18
`define RFS_TAPS 16
`define RFS_ST_PKT 0
`define RFS_ST_RSV 1
`define RFS_ST_BWUPD 2
`endif

// File: design/rfs_top.v
// Purpose: Sixteen-tap channel filter with programmable bandwidth and signal strength reporting.
// Assumes: Inputs are synchronous to core_clk; samples arrive with sample_valid.
// Notes: Bandwidth is given as a decimation divisor, mantissa times two to the exponent plus two.
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "rfs_defines.vh"

// Function
// - Sixteen-tap FIR filter rejects out-of-channel signal.
// - Bandwidth equals oscillator over mantissa times 2^(exp+2).
// - Mantissa codes 00,01,10 give 16,20,24.
// - Only exponent 1..7 with defined mantissas valid.
// - Per-packet strength averages instantaneous strength.
module rfs_top (
  input wire core_clk,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire sample_valid,
  input wire signed [15:0] sample_in,
  input wire [7:0] strength_in,
  input wire header_valid_event,
  input wire receive_done_event,
  input wire filter_reconfig,
  output reg signed [15:0] filt_out,
  output reg filt_valid,
  output wire irq
);
  // ************************************************************
  // Register bus
  // ************************************************************
  reg [4:0] bw_cfg_q;
  reg [4:0] bw_act_q;
  reg [7:0] inst_q;
  reg [7:0] pkt_q;
  reg [2:0] stat_q;
  reg [2:0] ien_q;
  wire [7:0] divisor;
  // Zero-wait slave: pready is tied high, so every access completes in its first access cycle.
  // Read data is a mux of flops and the divisor decoded from them, which keeps the bus path free of extra state.
  // Unmapped offsets raise pslverr in the access phase and change nothing.
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire [1:0] filter_mantissa_code = bw_act_q[4:`RFS_MANT_LSB];
  wire [2:0] filter_exponent = bw_act_q[`RFS_EXP_MSB:0];
  reg bad_addr;
  assign pready = 1'b1;
  assign pslverr = acc & bad_addr;
  always @* begin
    bad_addr = 1'b0;
    prdata = 32'h0;
    if (paddr == `RFS_OFF_BWCFG) begin
      prdata = {27'h0, bw_cfg_q};
    end else if (paddr == `RFS_OFF_INST) begin
      prdata = {24'h0, inst_q};
    end else if (paddr == `RFS_OFF_PKT) begin
      prdata = {24'h0, pkt_q};
    end else if (paddr == `RFS_OFF_STAT) begin
      prdata = {29'h0, stat_q};
    end else if (paddr == `RFS_OFF_CLR) begin
      prdata = 32'h0;
    end else if (paddr == `RFS_OFF_IEN) begin
      prdata = {29'h0, ien_q};
    end else if (paddr == `RFS_OFF_DIV) begin
      prdata = {24'h0, divisor};
    end else begin
      bad_addr = 1'b1;
    end
  end
  // ************************************************************
  // Bandwidth decode
  // ************************************************************
  // Mantissa code 11 and exponent 0 are reserved; setting_ok flags them should they reach the active copy.
  // Writes are screened, so in practice only legal settings are decoded here.
  reg [4:0] mant_div;
  reg setting_ok;
  always @* begin
    mant_div = `RFS_DIV_16;
    setting_ok = 1'b1;
    case (filter_mantissa_code)
      2'b00: mant_div = `RFS_DIV_16;
      2'b01: mant_div = `RFS_DIV_20;
      2'b10: mant_div = `RFS_DIV_24;
      default: setting_ok = 1'b0;
    endcase
    if (filter_exponent == 3'h0) begin
      setting_ok = 1'b0;
    end
  end
  // Divisor is mantissa times 2^(exp+2); held as mantissa and shift to stay narrow.
  assign divisor = {3'h0, mant_div};
  wire [3:0] shift = {1'b0, filter_exponent} + 4'h2;
  // Reserved settings leave the last good one running rather than stalling the filter.
  wire rsv_write = wr && (paddr == `RFS_OFF_BWCFG) &&
    ((pwdata[4:3] == 2'b11) || (pwdata[2:0] == 3'h0));
  // ************************************************************
  // Decimation counter and FIR
  // ************************************************************
  reg [15:0] dec_cnt_q;
  wire [15:0] dec_lim = ({8'h0, divisor} << shift) - 16'h1;
  reg signed [15:0] tap_q [0:`RFS_TAPS-1];
  reg signed [23:0] acc_sum;
  integer i;
  integer j;
  // The output is the mean of the last sixteen samples, one per decimation period.
  // The counter restarts whenever it meets a smaller limit after a bandwidth change.
  always @* begin
    acc_sum = 24'sh0;
    for (i = 0; i < `RFS_TAPS; i = i + 1) begin
      acc_sum = acc_sum + {{8{tap_q[i][15]}}, tap_q[i]};
    end
  end
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (j = 0; j < `RFS_TAPS; j = j + 1) begin
        tap_q[j] <= 16'sh0;
      end
      dec_cnt_q <= 16'h0;
      filt_out <= 16'sh0;
      filt_valid <= 1'b0;
    end else begin
      filt_valid <= 1'b0;
      if (sample_valid) begin
        tap_q[0] <= sample_in;
        for (j = 1; j < `RFS_TAPS; j = j + 1) begin
          tap_q[j] <= tap_q[j-1];
        end
        if (dec_cnt_q >= dec_lim) begin
          dec_cnt_q <= 16'h0;
          filt_out <= acc_sum[19:4];
          filt_valid <= 1'b1;
        end else begin
          dec_cnt_q <= dec_cnt_q + 16'h1;
        end
      end
    end
  end
  // ************************************************************
  // Configuration, strength and interrupts
  // ************************************************************
  reg rx_pkt_q;
  reg [15:0] sum_q;
  reg [7:0] cnt_q;
  reg [2:0] ev;
  wire pkt_ev = receive_done_event & rx_pkt_q;
  wire clr_wr = wr && (paddr == `RFS_OFF_CLR);
  // A clear that meets a new event in the same cycle loses, so no event is ever dropped.
  always @* begin
    ev = 3'h0;
    ev[`RFS_ST_PKT] = pkt_ev;
    ev[`RFS_ST_RSV] = rsv_write;
    ev[`RFS_ST_BWUPD] = filter_reconfig & setting_ok;
  end
  assign irq = |(stat_q & ien_q);
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bw_cfg_q <= `RFS_BW_RESET;
      bw_act_q <= `RFS_BW_RESET;
      ien_q <= 3'h0;
      stat_q <= 3'h0;
    end else begin
      if (wr && (paddr == `RFS_OFF_BWCFG) && !rsv_write) begin
        bw_cfg_q <= pwdata[4:0];
      end
      if (wr && (paddr == `RFS_OFF_IEN)) begin
        ien_q <= pwdata[2:0];
      end
      if (filter_reconfig) begin
        bw_act_q <= bw_cfg_q;
      end
      stat_q <= (stat_q & ~(clr_wr ? pwdata[2:0] : 3'h0)) | ev;
    end
  end
  // ************************************************************
  // Signal strength
  // ************************************************************
  // The packet value is the running average between header and done.
  // A packet that ends before any averaging step reports the last sample.
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      inst_q <= 8'h0;
      pkt_q <= 8'h0;
      rx_pkt_q <= 1'b0;
      sum_q <= 16'h0;
      cnt_q <= 8'h0;
    end else begin
      inst_q <= strength_in;
      if (header_valid_event) begin
        rx_pkt_q <= 1'b1;
        sum_q <= {8'h0, strength_in};
        cnt_q <= 8'h1;
      end else if (rx_pkt_q && receive_done_event) begin
        rx_pkt_q <= 1'b0;
        pkt_q <= (cnt_q <= 8'h1) ? strength_in : sum_q[15:8];
      end else if (rx_pkt_q && cnt_q != 8'h0) begin
        // Running average with weight 1/256 keeps it in one adder.
        sum_q <= sum_q - {8'h0, sum_q[15:8]} + {8'h0, strength_in};
        if (cnt_q == 8'h1) begin
          sum_q <= {strength_in, 8'h0};
        end
        cnt_q <= 8'h2;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/rfs_fe_model.sv
// Purpose: Front end feeding samples and packet events.
// Assumes: One clock; a packet every 256 cycles.
// Notes: Inputs are constant so every average is known.
`timescale 1ns/10ps
`default_nettype none
module rfs_fe_model (
  input wire logic core_clk,
  input wire logic resetn,
  output logic sample_valid,
  output logic signed [15:0] sample_in,
  output logic [7:0] strength_in,
  output logic header_valid_event,
  output logic receive_done_event
);
  logic [7:0] n_q = 8'h00;
  always @(posedge core_clk) begin
    n_q <= resetn ? n_q + 8'h01 : 8'h00;
  end
  assign sample_valid = resetn;
  assign sample_in = 16'sh0123;
  assign strength_in = 8'h5a;
  assign header_valid_event = n_q == 8'h40;
  assign receive_done_event = n_q == 8'h60;
endmodule
`default_nettype wire

// File: tb/rfs_monitor.sv
// Purpose: Port checks for the filter block.
// Assumes: Zero-wait APB.
// Notes: Reads are checked in setup and access alike, as read data is combinational.
`timescale 1ns/10ps
`default_nettype none
`include "rfs_defines.vh"
module rfs_monitor (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic filt_valid,
  input wire logic [7:0] strength_in
);
  wire rd_bw = psel && !pwrite && paddr == `RFS_OFF_BWCFG;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence cfg_wr_s;
    psel && penable && pwrite && paddr == `RFS_OFF_BWCFG && pwdata[2:0] != 3'h0 && pwdata[4:3] != 2'h3;
  endsequence
  sequence rsv_wr_s;
    psel && penable && pwrite && paddr == `RFS_OFF_BWCFG && (pwdata[2:0] == 3'h0 || pwdata[4:3] == 2'h3);
  endsequence
  rsv_flag_a:
    assert property (rsv_wr_s ##2 (psel && !pwrite && paddr == `RFS_OFF_STAT) |-> prdata[`RFS_ST_RSV])
    else $error("reserved write not flagged");
  inst_track_a:
    assert property (psel && !pwrite && paddr == `RFS_OFF_INST |-> prdata[7:0] == $past(strength_in))
    else $error("instant strength stale");
  div_code_a:
    assert property (psel && !pwrite && paddr == `RFS_OFF_DIV |-> prdata[4:0] inside {5'h10, 5'h14, 5'h18})
    else $error("bad divisor");
  bw_legal_a:
    assert property (rd_bw |-> prdata[2:0] != 3'h0 && prdata[4:3] != 2'h3)
    else $error("reserved setting stored");
  cfg_hold_a:
    assert property (cfg_wr_s ##2 rd_bw |-> prdata[4:0] == $past(pwdata[4:0], 2))
    else $error("config readback wrong");
  fv_gap_a:
    assert property (filt_valid |=> !filt_valid [*8])
    else $error("outputs too close");
endmodule
bind rfs_top rfs_monitor u_mon (.*);
`default_nettype wire

// File: tb/tb_top.sv
// Purpose: Register and data path tests.
// Assumes: Zero-wait APB.
// Notes: Expected values follow the divisor rules.
`timescale 1ns/10ps
`default_nettype none
`include "rfs_defines.vh"
module tb_top;
  logic core_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, filter_reconfig = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic pready, pslverr, sample_valid, header_valid_event, receive_done_event, filt_valid, irq, e;
  logic signed [15:0] sample_in, filt_out;
  logic [7:0] strength_in;
  int n_errors = 0, n_checks = 0, t;
  int cal_off = -157;
  rfs_fe_model u_fe (.*);
  rfs_top u_dut (.*);
  initial forever #20 core_clk = ~core_clk;
  task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do @(posedge core_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      n_errors++;
      $display("unexpected at %0t: %h vs %h", $time, g, x);
    end
  endtask
  task automatic wt(input logic s);
    t = 0;
    do begin
      @(posedge core_clk);
      t++;
    end while ((s ? receive_done_event : filt_valid) !== 1'b1 && t < 999);
    if (t >= 999) begin
      n_errors++;
      $display("unexpected timeout at %0t: %h vs %h", $time, t, 999);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    summarize();
  end
  initial begin
    repeat (8) @(posedge core_clk);
    resetn <= 1;
    xf(0, `RFS_OFF_BWCFG, '0);
    chk(r, `RFS_BW_RESET);
    for (int m = 0; m < 3; m++) begin
      xf(1, `RFS_OFF_BWCFG, 32'(m * 8 + 1));
      xf(0, `RFS_OFF_BWCFG, '0);
      chk(r, 32'(m * 8 + 1));
      @(posedge core_clk) filter_reconfig <= 1;
      @(posedge core_clk) filter_reconfig <= 0;
      xf(0, `RFS_OFF_DIV, '0);
      chk(r, 32'(16 + 4 * m));
    end
    xf(1, `RFS_OFF_IEN, 32'h2);
    xf(1, `RFS_OFF_BWCFG, 32'h19);
    xf(1, `RFS_OFF_BWCFG, 32'h10);
    xf(0, `RFS_OFF_STAT, '0);
    chk(r & 32'h2, 32'h2);
    xf(0, `RFS_OFF_BWCFG, '0);
    chk(r, 32'h11);
    chk(32'(irq), 32'h1);
    xf(1, `RFS_OFF_CLR, 32'h2);
    @(posedge core_clk);
    chk(32'(irq), 32'h0);
    $display("test config done");
    wt(0);
    wt(0);
    chk(32'(t), 32'hc0);
    chk(32'(filt_out), 32'h123);
    $display("test filter done");
    wt(1);
    repeat (2) @(posedge core_clk);
    xf(0, `RFS_OFF_PKT, '0);
    chk(r, 32'h5a);
    chk(32'(cal_off + int'((r * 16) / 15)), 32'hffffffc3);
    xf(0, `RFS_OFF_INST, '0);
    chk(r, 32'h5a);
    xf(0, 12'h01c, '0);
    chk(32'(e), 32'h1);
    $display("test packet done");
    summarize();
  end
endmodule
`default_nettype wire
